// ==== rtl/sws_pkg.sv ====
// shared constants, types and helpers for the i/o select and write-protect bank
package sws_pkg;

  // bus widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] SYSIO_ADDR = 32'h400e0314;
  localparam logic [ADDR_W-1:0] PMODE_ADDR = 32'h400e03e4;
  localparam logic [ADDR_W-1:0] PSTAT_ADDR = 32'h400e03e8;
  localparam logic [ADDR_W-1:0] INT_STAT_ADDR = 32'h400e03f0;
  localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 32'h400e03f4;
  // base that violation offsets are measured from
  localparam logic [ADDR_W-1:0] OFFSET_BASE = 32'h400e0200;

  // pin function select field positions
  localparam int unsigned PIN4_BIT = 4;
  localparam int unsigned PIN5_BIT = 5;
  localparam int unsigned PIN6_BIT = 6;
  localparam int unsigned PIN7_BIT = 7;
  localparam int unsigned PIN12_BIT = 12;

  // protect mode layout
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned KEY_LSB = 8;
  localparam int unsigned KEY_MSB = 31;
  localparam logic [KEY_MSB-KEY_LSB:0] PROTECT_KEY = 24'h4d4154;

  // protect status layout
  localparam int unsigned VFLAG_BIT = 0;
  localparam int unsigned SRC_LSB = 8;
  localparam int unsigned SRC_MSB = 23;
  localparam int unsigned SRC_W = SRC_MSB - SRC_LSB + 1;
  localparam logic [SRC_W-1:0] SYSIO_OFS = SRC_W'(SYSIO_ADDR - OFFSET_BASE);

  // reset values
  localparam logic PROTECT_RST = 1'b0;
  localparam logic [SRC_W-1:0] SRC_RST = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // interrupt event bits
  localparam int unsigned EV_W = 2;
  localparam int unsigned EV_VIOLATION = 0;
  localparam int unsigned EV_BAD_KEY = 1;
  localparam logic [EV_W-1:0] EV_NONE = 2'h0;

  // one bit per routed pin, 1 selects the port line
  typedef struct packed {
    logic pin12_function_select;
    logic pin7_function_select;
    logic pin6_function_select;
    logic pin5_function_select;
    logic pin4_function_select;
  } sws_pin_sel_t;

  localparam sws_pin_sel_t SYSIO_RST = 5'h00;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sws_bus_req_t;

  // address match
  function automatic logic sws_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
    return a == t;
  endfunction

  // key field of a protect mode write
  function automatic logic [KEY_MSB-KEY_LSB:0] sws_key_of(input logic [DATA_W-1:0] d);
    return d[KEY_MSB:KEY_LSB];
  endfunction

endpackage

// ==== rtl/sws_wp_guard.sv ====
// write-protect gate: decides which writes may land and which are violations
`timescale 1ns/1ps
`default_nettype none
module sws_wp_guard (
  input wire sws_pkg::sws_bus_req_t bus_req,
  input wire logic protect_en,
  output logic sysio_wr_ok,
  output logic sysio_blocked,
  output logic key_wr_ok,
  output logic key_wr_bad
);

  logic sysio_wr;
  logic pmode_wr;

  // classify the current write
  always_comb
  begin
    sysio_wr = bus_req.wr && sws_pkg::sws_hit(bus_req.addr, sws_pkg::SYSIO_ADDR);
    pmode_wr = bus_req.wr && sws_pkg::sws_hit(bus_req.addr, sws_pkg::PMODE_ADDR);
    sysio_wr_ok = sysio_wr && !protect_en;
    sysio_blocked = sysio_wr && protect_en;
    key_wr_ok = pmode_wr && (sws_pkg::sws_key_of(bus_req.wdata) == sws_pkg::PROTECT_KEY);
    key_wr_bad = pmode_wr && (sws_pkg::sws_key_of(bus_req.wdata) != sws_pkg::PROTECT_KEY);
  end

endmodule
`default_nettype wire

// ==== rtl/sws_irq_ctl.sv ====
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module sws_irq_ctl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [sws_pkg::EV_W-1:0] events,
  input wire logic wr_stat,
  input wire logic wr_mask,
  input wire logic [sws_pkg::EV_W-1:0] wdata,
  output logic [sws_pkg::EV_W-1:0] status,
  output logic [sws_pkg::EV_W-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [sws_pkg::EV_W-1:0] status;
    logic [sws_pkg::EV_W-1:0] mask;
    logic irq;
  } sws_irq_st_t;

  sws_irq_st_t st_q;
  sws_irq_st_t st_d;

  // write one to clear, a new event in the same cycle wins
  always_comb
  begin
    st_d = st_q;
    if (wr_stat)
    begin
      st_d.status = st_q.status & ~wdata;
    end
    st_d.status = st_d.status | events;
    if (wr_mask)
    begin
      st_d.mask = wdata;
    end
    st_d.irq = |(st_d.status & st_d.mask);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign status = st_q.status;
  assign mask = st_q.mask;
  assign irq = st_q.irq;

  // an event is never lost to a clear
  event_sticks_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (events != sws_pkg::EV_NONE) |=> ((st_q.status & $past(events)) == $past(events)))
    else $error("event bit not set after event");

endmodule
`default_nettype wire

// ==== rtl/sws_sysio_bank.sv ====
// system i/o select register with keyed write protection and violation status
`timescale 1ns/1ps
`default_nettype none
module sws_sysio_bank (
  input wire logic mclk,
  input wire logic rst_n,
  input wire sws_pkg::sws_bus_req_t bus_req,
  output logic [sws_pkg::DATA_W-1:0] rdata,
  output var sws_pkg::sws_pin_sel_t pin_sel,
  output logic protect_on,
  output logic irq
);

  // bank state except the interrupt status and mask, which u_irq holds
  typedef struct packed {
    sws_pkg::sws_pin_sel_t sysio;
    logic protect_enable;
    logic violation_flag;
    logic [sws_pkg::SRC_W-1:0] violation_source;
    logic [sws_pkg::DATA_W-1:0] rdata;
  } sws_bank_st_t;

  sws_bank_st_t st_q;
  sws_bank_st_t st_d;

  logic sysio_wr_ok;
  logic sysio_blocked;
  logic key_wr_ok;
  logic key_wr_bad;
  logic rd_sysio;
  logic rd_pmode;
  logic rd_pstat;
  logic rd_istat;
  logic rd_imask;
  logic wr_istat;
  logic wr_imask;
  logic [sws_pkg::EV_W-1:0] events;
  logic [sws_pkg::EV_W-1:0] int_status;
  logic [sws_pkg::EV_W-1:0] int_mask;

  // protection gate on incoming writes
  sws_wp_guard u_guard (
    .bus_req(bus_req),
    .protect_en(st_q.protect_enable),
    .sysio_wr_ok(sysio_wr_ok),
    .sysio_blocked(sysio_blocked),
    .key_wr_ok(key_wr_ok),
    .key_wr_bad(key_wr_bad)
  );

  // strobe decode for reads and interrupt registers
  always_comb
  begin
    rd_sysio = bus_req.rd && sws_pkg::sws_hit(bus_req.addr, sws_pkg::SYSIO_ADDR);
    rd_pmode = bus_req.rd && sws_pkg::sws_hit(bus_req.addr, sws_pkg::PMODE_ADDR);
    rd_pstat = bus_req.rd && sws_pkg::sws_hit(bus_req.addr, sws_pkg::PSTAT_ADDR);
    rd_istat = bus_req.rd && sws_pkg::sws_hit(bus_req.addr, sws_pkg::INT_STAT_ADDR);
    rd_imask = bus_req.rd && sws_pkg::sws_hit(bus_req.addr, sws_pkg::INT_MASK_ADDR);
    wr_istat = bus_req.wr && sws_pkg::sws_hit(bus_req.addr, sws_pkg::INT_STAT_ADDR);
    wr_imask = bus_req.wr && sws_pkg::sws_hit(bus_req.addr, sws_pkg::INT_MASK_ADDR);
    events = sws_pkg::EV_NONE;
    events[sws_pkg::EV_VIOLATION] = sysio_blocked;
    events[sws_pkg::EV_BAD_KEY] = key_wr_bad;
  end

  // sticky events, mask and interrupt line
  sws_irq_ctl u_irq (
    .mclk(mclk),
    .rst_n(rst_n),
    .events(events),
    .wr_stat(wr_istat),
    .wr_mask(wr_imask),
    .wdata(bus_req.wdata[sws_pkg::EV_W-1:0]),
    .status(int_status),
    .mask(int_mask),
    .irq(irq)
  );

  // next state of the bank
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = sws_pkg::WORD_ZERO;
    // pin routing bits land only through the gate
    if (sysio_wr_ok)
    begin
      st_d.sysio.pin4_function_select = bus_req.wdata[sws_pkg::PIN4_BIT];
      st_d.sysio.pin5_function_select = bus_req.wdata[sws_pkg::PIN5_BIT];
      st_d.sysio.pin6_function_select = bus_req.wdata[sws_pkg::PIN6_BIT];
      st_d.sysio.pin7_function_select = bus_req.wdata[sws_pkg::PIN7_BIT];
      st_d.sysio.pin12_function_select = bus_req.wdata[sws_pkg::PIN12_BIT];
    end
    // keyed protect enable, a bad key aborts the update
    if (key_wr_ok)
    begin
      st_d.protect_enable = bus_req.wdata[sws_pkg::ENABLE_BIT];
    end
    // status read clears the flag
    if (rd_pstat)
    begin
      st_d.violation_flag = 1'b0;
    end
    // a blocked write sets the flag, winning over a same-cycle clear
    if (sysio_blocked)
    begin
      st_d.violation_flag = 1'b1;
      st_d.violation_source = sws_pkg::SYSIO_OFS;
    end
    // read data for the cycle after the strobe
    if (rd_sysio)
    begin
      st_d.rdata[sws_pkg::PIN4_BIT] = st_q.sysio.pin4_function_select;
      st_d.rdata[sws_pkg::PIN5_BIT] = st_q.sysio.pin5_function_select;
      st_d.rdata[sws_pkg::PIN6_BIT] = st_q.sysio.pin6_function_select;
      st_d.rdata[sws_pkg::PIN7_BIT] = st_q.sysio.pin7_function_select;
      st_d.rdata[sws_pkg::PIN12_BIT] = st_q.sysio.pin12_function_select;
    end
    else if (rd_pmode)
    begin
      st_d.rdata[sws_pkg::ENABLE_BIT] = st_q.protect_enable; // key field stays zero
    end
    else if (rd_pstat)
    begin
      st_d.rdata[sws_pkg::VFLAG_BIT] = st_q.violation_flag;
      st_d.rdata[sws_pkg::SRC_MSB:sws_pkg::SRC_LSB] = st_q.violation_source;
    end
    else if (rd_istat)
    begin
      st_d.rdata[sws_pkg::EV_W-1:0] = int_status;
    end
    else if (rd_imask)
    begin
      st_d.rdata[sws_pkg::EV_W-1:0] = int_mask;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.sysio <= sws_pkg::SYSIO_RST;
      st_q.protect_enable <= sws_pkg::PROTECT_RST;
      st_q.violation_flag <= 1'b0;
      st_q.violation_source <= sws_pkg::SRC_RST;
      st_q.rdata <= sws_pkg::WORD_ZERO;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign rdata = st_q.rdata;
  assign pin_sel = st_q.sysio;
  assign protect_on = st_q.protect_enable;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // port line four follows an accepted write
  pin4_route_a: assert property (sysio_wr_ok
    |=> pin_sel.pin4_function_select == $past(bus_req.wdata[sws_pkg::PIN4_BIT]))
    else $error("pin 4 select did not follow write");

  // port line five follows an accepted write
  pin5_route_a: assert property (sysio_wr_ok
    |=> pin_sel.pin5_function_select == $past(bus_req.wdata[sws_pkg::PIN5_BIT]))
    else $error("pin 5 select did not follow write");

  // port line six follows an accepted write
  pin6_route_a: assert property (sysio_wr_ok
    |=> pin_sel.pin6_function_select == $past(bus_req.wdata[sws_pkg::PIN6_BIT]))
    else $error("pin 6 select did not follow write");

  // port line seven follows an accepted write
  pin7_route_a: assert property (sysio_wr_ok
    |=> pin_sel.pin7_function_select == $past(bus_req.wdata[sws_pkg::PIN7_BIT]))
    else $error("pin 7 select did not follow write");

  // port line twelve follows an accepted write
  pin12_route_a: assert property (sysio_wr_ok
    |=> pin_sel.pin12_function_select == $past(bus_req.wdata[sws_pkg::PIN12_BIT]))
    else $error("pin 12 select did not follow write");

  // select register writes pass only when unprotected
  sysio_gate_a: assert property ((bus_req.wr
    && sws_pkg::sws_hit(bus_req.addr, sws_pkg::SYSIO_ADDR)) |-> (sysio_wr_ok == !protect_on))
    else $error("select write gate disagrees with protect state");

  // key writes set the enable to the written bit
  key_update_a: assert property ((bus_req.wr
    && sws_pkg::sws_hit(bus_req.addr, sws_pkg::PMODE_ADDR)
    && sws_pkg::sws_key_of(bus_req.wdata) == sws_pkg::PROTECT_KEY)
    |=> protect_on == $past(bus_req.wdata[sws_pkg::ENABLE_BIT]))
    else $error("protect enable did not take keyed write");

  // a wrong key leaves the enable untouched
  bad_key_a: assert property ((bus_req.wr
    && sws_pkg::sws_hit(bus_req.addr, sws_pkg::PMODE_ADDR)
    && sws_pkg::sws_key_of(bus_req.wdata) != sws_pkg::PROTECT_KEY)
    |=> $stable(protect_on))
    else $error("protect enable changed on wrong key");

  // key field reads back as zero
  key_reads_zero_a: assert property (rd_pmode
    |=> (rdata[sws_pkg::KEY_MSB:sws_pkg::KEY_LSB] == '0)
    && (rdata[sws_pkg::ENABLE_BIT] == protect_on))
    else $error("protect mode read shows key bits");

  // status read returns then clears the flag unless a new violation lands
  flag_clear_a: assert property ((rd_pstat && !sysio_blocked)
    |=> !st_q.violation_flag
    && rdata[sws_pkg::VFLAG_BIT] == $past(st_q.violation_flag))
    else $error("violation flag not returned and cleared by read");

  // blocked write records the offset and sets the flag
  viol_record_a: assert property (sysio_blocked
    |=> st_q.violation_flag
    && st_q.violation_source == sws_pkg::SYSIO_OFS)
    else $error("violation not recorded with offset");

  // the source shows on a status read
  src_read_a: assert property (rd_pstat
    |=> rdata[sws_pkg::SRC_MSB:sws_pkg::SRC_LSB] == $past(st_q.violation_source))
    else $error("violation source not returned on read");

  // a blocked write leaves routing unchanged next cycle, and the cycle after unless a write was accepted
  blocked_hold_a: assert property (sysio_blocked
    |=> $stable(pin_sel) ##1 ($stable(pin_sel) || $past(sysio_wr_ok)))
    else $error("protected select register changed");

  // the flag holds until a status read
  flag_holds_a: assert property ((st_q.violation_flag && !rd_pstat)
    |=> st_q.violation_flag)
    else $error("violation flag dropped without a status read");

  // the flag rises only on a violation
  flag_needs_viol_a: assert property ((!st_q.violation_flag && !sysio_blocked)
    |=> !st_q.violation_flag)
    else $error("violation flag set without a violation");

  // the source moves only on a blocked write
  src_holds_a: assert property (!sysio_blocked
    |=> $stable(st_q.violation_source))
    else $error("violation source changed without a violation");

  // while the flag is set the source names the select register
  src_valid_a: assert property (st_q.violation_flag
    |-> st_q.violation_source == sws_pkg::SYSIO_OFS)
    else $error("violation source wrong while flag set");

  // the source survives the clearing read
  src_kept_a: assert property ((rd_pstat && !sysio_blocked)
    |=> $stable(st_q.violation_source))
    else $error("violation source lost on status read");

  // unused status bits read as zero
  pstat_reserved_a: assert property (rd_pstat
    |=> rdata[sws_pkg::SRC_LSB-1:sws_pkg::VFLAG_BIT+1] == '0
    && rdata[sws_pkg::DATA_W-1:sws_pkg::SRC_MSB+1] == '0)
    else $error("status read shows reserved bits");

  // the flag shows on a read while set
  flag_set_read_a: assert property ((rd_pstat && st_q.violation_flag)
    |=> rdata[sws_pkg::VFLAG_BIT])
    else $error("set violation flag not returned on read");

  // protect enable moves only on a keyed write
  protect_holds_a: assert property (!key_wr_ok
    |=> $stable(protect_on))
    else $error("protect enable changed without keyed write");

  // a wrong key touches neither routing nor protection
  bad_key_quiet_a: assert property (key_wr_bad
    |=> $stable(pin_sel) && $stable(protect_on))
    else $error("wrong key write changed state");

  // unused protect mode bits read as zero
  pmode_reserved_a: assert property (rd_pmode
    |=> rdata[sws_pkg::KEY_LSB-1:sws_pkg::ENABLE_BIT+1] == '0)
    else $error("protect mode read shows reserved bits");

  // routing moves only on an accepted write
  sysio_holds_a: assert property (!sysio_wr_ok
    |=> $stable(pin_sel))
    else $error("select register changed without accepted write");

  // protection on closes the gate
  protect_blocks_a: assert property (protect_on |-> !sysio_wr_ok)
    else $error("select write accepted while protected");

  // a select write either lands or is blocked, never both
  gate_exclusive_a: assert property (!(sysio_wr_ok && sysio_blocked))
    else $error("select write both accepted and blocked");

  // a blocked write raises the violation event
  viol_event_a: assert property (sysio_blocked
    |=> int_status[sws_pkg::EV_VIOLATION])
    else $error("blocked write did not raise its event");

  // a wrong key raises its event
  bad_key_event_a: assert property (key_wr_bad
    |=> int_status[sws_pkg::EV_BAD_KEY])
    else $error("wrong key write did not raise its event");

  // a select read returns the five routing bits and nothing else
  sysio_read_a: assert property (rd_sysio
    |=> rdata[sws_pkg::PIN4_BIT] == $past(pin_sel.pin4_function_select)
    && rdata[sws_pkg::PIN5_BIT] == $past(pin_sel.pin5_function_select)
    && rdata[sws_pkg::PIN6_BIT] == $past(pin_sel.pin6_function_select)
    && rdata[sws_pkg::PIN7_BIT] == $past(pin_sel.pin7_function_select)
    && rdata[sws_pkg::PIN12_BIT] == $past(pin_sel.pin12_function_select)
    && $countones(rdata) == $countones($past(pin_sel)))
    else $error("select read data wrong");

  // interrupt line tracks the unmasked status
  irq_level_a: assert property (irq == (|(int_status & int_mask)))
    else $error("interrupt line disagrees with status and mask");

  // nothing is raised with every source masked
  irq_masked_a: assert property ((int_mask == sws_pkg::EV_NONE) |-> !irq)
    else $error("interrupt raised while fully masked");

  // events come only from writes
  events_need_write_a: assert property ((events != sws_pkg::EV_NONE) |-> bus_req.wr)
    else $error("event raised without a write");

  // read data live only for one cycle after a strobe
  rdata_idle_a: assert property (!bus_req.rd |=> rdata == sws_pkg::WORD_ZERO)
    else $error("read data present without a read");

endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the i/o select and write-protect register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk;
  logic rst_n;
  sws_pkg::sws_bus_req_t bus_req;
  logic [sws_pkg::DATA_W-1:0] rdata;
  sws_pkg::sws_pin_sel_t pin_sel;
  logic protect_on;
  logic irq;
  int bad_count;
  int checks_done;
  int bit_pos [5] = '{4, 5, 6, 7, 12};
  // key words: right key and a wrong one, enable bit in bit 0
  localparam logic [31:0] KEY_ON = 32'h4d41_5401;
  localparam logic [31:0] KEY_OFF = 32'h4d41_5400;
  localparam logic [31:0] BAD_ON = 32'h1234_5601;
  localparam logic [31:0] BAD_OFF = 32'h1234_5600;

  sws_sysio_bank dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .rdata(rdata),
    .pin_sel(pin_sel),
    .protect_on(protect_on),
    .irq(irq)
  );

  // free-running 200 mhz clock
  always #2.5 mclk = ~mclk;

  // verdict and end of run
  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // compare one value, report a mismatch
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, returns once the effect has landed
  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: addr, wdata: data};
    #1;
  endtask

  // one-cycle read strobe, data sampled in the following cycle
  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0000_0000};
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: addr, wdata: 32'h0000_0000};
    #1;
    check(rdata, exp);
  endtask

  // watchdog: tests need well under a microsecond
  initial
  begin
    #5000;
    bad_count++;
    complete_run();
  end

  // main sequence
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    bad_count = 0;
    checks_done = 0;
    bus_req = '{wr: 1'b0, rd: 1'b0, addr: 32'h0000_0000, wdata: 32'h0000_0000};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    // reset state: debug functions, protection off, no interrupt
    check(32'(pin_sel), 32'h0000_0000);
    check(32'(protect_on), 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    rd_chk(sws_pkg::SYSIO_ADDR, 32'h0000_0000);
    rd_chk(sws_pkg::PSTAT_ADDR, 32'h0000_0000);
    // each select bit alone routes only its own pin to the port line
    for (int i = 0; i < 5; i++)
    begin
      wr(sws_pkg::SYSIO_ADDR, 32'h1 << bit_pos[i]);
      check(32'(pin_sel), 32'h1 << i);
      rd_chk(sws_pkg::SYSIO_ADDR, 32'h1 << bit_pos[i]);
    end
    wr(sws_pkg::SYSIO_ADDR, 32'h0000_10f0);
    check(32'(pin_sel), 32'h0000_001f);
    // wrong key cannot enable, key field reads zero
    wr(sws_pkg::PMODE_ADDR, BAD_ON);
    check(32'(protect_on), 32'h0000_0000);
    rd_chk(sws_pkg::PMODE_ADDR, 32'h0000_0000);
    // right key enables, key still reads zero
    wr(sws_pkg::PMODE_ADDR, KEY_ON);
    check(32'(protect_on), 32'h0000_0001);
    rd_chk(sws_pkg::PMODE_ADDR, 32'h0000_0001);
    // blocked select write keeps contents and records offset 0x0114
    wr(sws_pkg::SYSIO_ADDR, 32'h0000_0000);
    check(32'(pin_sel), 32'h0000_001f);
    rd_chk(sws_pkg::SYSIO_ADDR, 32'h0000_10f0);
    rd_chk(sws_pkg::PSTAT_ADDR, 32'h0001_1401);
    rd_chk(sws_pkg::PSTAT_ADDR, 32'h0001_1400);
    // wrong key cannot disable
    wr(sws_pkg::PMODE_ADDR, BAD_OFF);
    check(32'(protect_on), 32'h0000_0001);
    // interrupt: both events pending, masked, unmasked, cleared
    rd_chk(sws_pkg::INT_STAT_ADDR, 32'h0000_0003);
    check(32'(irq), 32'h0000_0000);
    wr(sws_pkg::INT_MASK_ADDR, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wr(sws_pkg::INT_STAT_ADDR, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    rd_chk(sws_pkg::INT_STAT_ADDR, 32'h0000_0002);
    wr(sws_pkg::INT_MASK_ADDR, 32'h0000_0003);
    check(32'(irq), 32'h0000_0001);
    rd_chk(sws_pkg::INT_MASK_ADDR, 32'h0000_0003);
    wr(sws_pkg::INT_STAT_ADDR, 32'h0000_0002);
    check(32'(irq), 32'h0000_0000);
    rd_chk(sws_pkg::INT_STAT_ADDR, 32'h0000_0000);
    // right key disables, select writes land again
    wr(sws_pkg::PMODE_ADDR, KEY_OFF);
    check(32'(protect_on), 32'h0000_0000);
    wr(sws_pkg::SYSIO_ADDR, 32'h0000_0050);
    check(32'(pin_sel), 32'h0000_0005);
    rd_chk(sws_pkg::PSTAT_ADDR, 32'h0001_1400);
    // unmapped address: write ignored, read gives zero
    wr(32'h400e_0318, 32'hffff_ffff);
    check(32'(pin_sel), 32'h0000_0005);
    rd_chk(32'h400e_0318, 32'h0000_0000);
    // second reset in mid-run, with a violation and the interrupt pending
    wr(sws_pkg::PMODE_ADDR, KEY_ON);
    wr(sws_pkg::SYSIO_ADDR, 32'h0000_0000);
    check(32'(pin_sel), 32'h0000_0005);
    check(32'(irq), 32'h0000_0001);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    check(32'(pin_sel), 32'h0000_0000);
    check(32'(protect_on), 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    check(rdata, 32'h0000_0000);
    rd_chk(sws_pkg::PSTAT_ADDR, 32'h0000_0000);
    rd_chk(sws_pkg::INT_STAT_ADDR, 32'h0000_0000);
    rd_chk(sws_pkg::INT_MASK_ADDR, 32'h0000_0000);
    complete_run();
  end
endmodule
`default_nettype wire
